// file: inc/dtdo_regs.svh
`ifndef DTDO_REGS_SVH
`define DTDO_REGS_SVH
`define DTDO_ADDR_CTRL      8'h00
`define DTDO_ADDR_STATUS    8'h04
`define DTDO_ADDR_IRQ_STAT  8'h08
`define DTDO_ADDR_IRQ_MASK  8'h0c
`define DTDO_ADDR_DIGIT     8'h10
`define DTDO_CTRL_FMT_BIT   0
`define DTDO_CTRL_INH_BIT   1
`define DTDO_CTRL_OE_BIT    2
`define DTDO_CTRL_OSC_BIT   3
`define DTDO_CTRL_CLR_BIT   4
`define DTDO_CTRL_RESET     32'h0000_0001
`define DTDO_IRQ_DETECT_BIT 0
`define DTDO_IRQ_PAUSE_BIT  1
`define DTDO_IRQ_CLEAR_BIT  2
`define DTDO_CLK_MHZ        250
`define DTDO_REF_KHZ        3579545
`define DTDO_REF_HALF_CYC   ((`DTDO_CLK_MHZ * 1000000) / (2 * `DTDO_REF_KHZ))
`endif

// file: inc/dtdo_pkg.sv
package dtdo_pkg;
	typedef enum logic [1:0] {DTDO_ST_IDLE, DTDO_ST_PRESENT, DTDO_ST_VALID} dtdo_state_t;
	typedef struct packed {
		logic [1:0] row;
		logic [1:0] col;
	} dtdo_pair_t;
	typedef struct packed {
		logic [3:0] code;
		logic       drive;
	} dtdo_out_t;
endpackage : dtdo_pkg

// file: hw/dtdo_decoder.sv
// Contract
// - Format select high gives hexadecimal codes, low gives two-of-eight codes.
// - Hexadecimal: digits 1-9 as value, 0=1010, *=1011, #=1100, A-C=1101-1111, D=0000.
// - Two-of-eight codes follow the fixed sixteen-entry table per digit.
// - Column inhibit high ignores every pair containing the top column.
// - Code outputs driven while output enable high, floating while low.
// - Code outputs update after full detection and clear after a timed pause.
// - Digit valid rises only once the code already stands on the outputs.
// - Digit valid holds until pause or clear input, whichever comes first; here a new accepted pair also drops it for one cycle.
// - Fourth column decoded only when not inhibited.
// - Oscillator enable drives the timebase clock out on the shared pin.
// - Internal timing derives from a colour-burst reference clock; here the timebase is divided from the 250 MHz system clock instead.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "dtdo_regs.svh"
module dtdo_decoder (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             pair_detect,
	input  wire logic [1:0]       pair_row,
	input  wire logic [1:0]       pair_col,
	input  wire logic             pause_detect,
	input  wire logic             digit_valid_clear,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic [1:0]            s_axi_bresp,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [7:0]       s_axi_araddr,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic [3:0]            code_out,
	output logic [3:0]            code_oe,
	output logic                  digit_valid,
	output logic                  shared_timebase,
	output logic                  shared_timebase_oe,
	output logic                  irq
);
	// Hex code per row/column
	function automatic logic [3:0] hex_code(input dtdo_pkg::dtdo_pair_t p);
		logic [3:0] t [0:15];
		t = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
			4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};
		return t[{p.row, p.col}];
	endfunction : hex_code

	function automatic logic [3:0] b28_code(input dtdo_pkg::dtdo_pair_t p);
		logic [3:0] t [0:15];
		t = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
			4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
		return t[{p.row, p.col}];
	endfunction : b28_code

	// Input synchronisers, two flops each
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic       clr_s1_reg;
	logic       clr_s2_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg  <= 6'h00;
			sync2_reg  <= 6'h00;
			clr_s1_reg <= 1'b0;
			clr_s2_reg <= 1'b0;
		end else begin
			sync1_reg  <= {pair_detect, pause_detect, pair_row, pair_col};
			sync2_reg  <= sync1_reg;
			clr_s1_reg <= digit_valid_clear;
			clr_s2_reg <= clr_s1_reg;
		end
	end

	logic                 det_s;
	logic                 pause_s;
	dtdo_pkg::dtdo_pair_t pair_s;
	assign det_s   = sync2_reg[5];
	assign pause_s = sync2_reg[4];
	assign pair_s  = dtdo_pkg::dtdo_pair_t'(sync2_reg[3:0]);

	// Register file state
	logic [31:0] ctrl_reg, ctrl_next;
	logic [2:0]  ist_reg, ist_next;
	logic [2:0]  imask_reg, imask_next;
	logic        bvalid_reg, bvalid_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        awrdy_reg, awrdy_next;
	logic        ardy_reg, ardy_next;

	// Decoder state
	dtdo_pkg::dtdo_state_t st_reg, st_next;
	logic [3:0] code_reg, code_next;
	logic       dv_reg, dv_next;
	logic       det_d_reg, det_d_next;
	logic       clr_d_reg, clr_d_next;
	logic       oe_reg, oe_next;
	logic       osc_reg, osc_next;
	logic       irq_reg, irq_next;
	localparam int HALF = `DTDO_REF_HALF_CYC;
	logic [7:0] tb_cnt_reg, tb_cnt_next;
	logic       tb_reg, tb_next;

	logic fmt_hex;
	logic inhibit;
	logic clr_req;
	logic det_rise;
	logic clr_rise;
	logic accept;
	logic ev_detect;
	logic ev_pause;
	logic ev_clear;
	logic wr_go;
	logic rd_go;
	logic [31:0] sw_clr_bits;

	assign fmt_hex  = ctrl_reg[`DTDO_CTRL_FMT_BIT];
	assign inhibit  = ctrl_reg[`DTDO_CTRL_INH_BIT];
	assign clr_req  = ctrl_reg[`DTDO_CTRL_CLR_BIT];
	assign det_rise = det_s && !det_d_reg;
	assign clr_rise = (clr_s2_reg && !clr_d_reg) || clr_req;
	assign accept   = det_rise && !(inhibit && pair_s.col == 2'd3);
	assign wr_go    = s_axi_awvalid && s_axi_wvalid && awrdy_reg;
	assign rd_go    = s_axi_arvalid && ardy_reg;
	assign sw_clr_bits = (wr_go && s_axi_awaddr == `DTDO_ADDR_IRQ_STAT && s_axi_wstrb[0]) ?
		s_axi_wdata : 32'h0;

	always_comb begin
		st_next    = st_reg;
		code_next  = code_reg;
		dv_next    = dv_reg;
		det_d_next = det_s;
		clr_d_next = clr_s2_reg;
		ev_detect  = 1'b0;
		ev_pause   = 1'b0;
		ev_clear   = 1'b0;
		case (st_reg)
			dtdo_pkg::DTDO_ST_IDLE: begin
				if (accept) begin
					code_next = fmt_hex ? hex_code(pair_s) : b28_code(pair_s);
					st_next   = dtdo_pkg::DTDO_ST_PRESENT;
				end
			end
			dtdo_pkg::DTDO_ST_PRESENT: begin
				// Code settles a cycle before valid rises
				dv_next   = 1'b1;
				ev_detect = 1'b1;
				st_next   = dtdo_pkg::DTDO_ST_VALID;
			end
			dtdo_pkg::DTDO_ST_VALID: begin
				if (pause_s) begin
					dv_next   = 1'b0;
					code_next = 4'h0;
					ev_pause  = 1'b1;
					st_next   = dtdo_pkg::DTDO_ST_IDLE;
				end else if (clr_rise && dv_reg) begin
					dv_next  = 1'b0;
					ev_clear = 1'b1;
				end else if (accept) begin
					code_next = fmt_hex ? hex_code(pair_s) : b28_code(pair_s);
					dv_next   = 1'b0;
					st_next   = dtdo_pkg::DTDO_ST_PRESENT;
				end
			end
			default: st_next = dtdo_pkg::DTDO_ST_IDLE;
		endcase
		oe_next  = ctrl_reg[`DTDO_CTRL_OE_BIT];
		osc_next = ctrl_reg[`DTDO_CTRL_OSC_BIT];
		// Timebase divided from system clock toward the reference rate
		tb_cnt_next = tb_cnt_reg + 8'h01;
		tb_next     = tb_reg;
		if (!osc_reg) begin
			tb_cnt_next = 8'h00;
			tb_next     = 1'b0;
		end else if (tb_cnt_reg >= 8'(HALF - 1)) begin
			tb_cnt_next = 8'h00;
			tb_next     = !tb_reg;
		end
	end

	// Bus slave and interrupt logic
	always_comb begin
		ctrl_next   = ctrl_reg;
		imask_next  = imask_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		// Ready waits for both valids, so aw and w are always taken together
		awrdy_next  = s_axi_awvalid && s_axi_wvalid && !awrdy_reg && !bvalid_reg;
		ardy_next   = s_axi_arvalid && !ardy_reg && !rvalid_reg;
		// One-shot software clear bit self-clears
		ctrl_next[`DTDO_CTRL_CLR_BIT] = 1'b0;
		if (wr_go) begin
			bvalid_next = 1'b1;
			bresp_next  = 2'b00;
			case (s_axi_awaddr)
				`DTDO_ADDR_CTRL: begin
					if (s_axi_wstrb[0])
						ctrl_next = {27'h0, s_axi_wdata[4:0]};
				end
				`DTDO_ADDR_IRQ_MASK: begin
					if (s_axi_wstrb[0])
						imask_next = s_axi_wdata[2:0];
				end
				`DTDO_ADDR_IRQ_STAT: ;
				default: bresp_next = 2'b10;
			endcase
		end
		// Set wins over a same-cycle clear
		ist_next = (ist_reg & ~sw_clr_bits[2:0]) | {ev_clear, ev_pause, ev_detect};
		irq_next = |(ist_next & imask_next);
		if (rd_go) begin
			rvalid_next = 1'b1;
			rresp_next  = 2'b00;
			case (s_axi_araddr)
				`DTDO_ADDR_CTRL:     rdata_next = ctrl_reg;
				`DTDO_ADDR_STATUS:   rdata_next = {28'h0, osc_reg, oe_reg, st_reg};
				`DTDO_ADDR_IRQ_STAT: rdata_next = {29'h0, ist_reg};
				`DTDO_ADDR_IRQ_MASK: rdata_next = {29'h0, imask_reg};
				`DTDO_ADDR_DIGIT:    rdata_next = {27'h0, dv_reg, code_reg};
				default: begin
					rdata_next = 32'h0;
					rresp_next = 2'b10;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg     <= dtdo_pkg::DTDO_ST_IDLE;
			code_reg   <= 4'h0;
			dv_reg     <= 1'b0;
			det_d_reg  <= 1'b0;
			clr_d_reg  <= 1'b0;
			oe_reg     <= 1'b0;
			osc_reg    <= 1'b0;
			irq_reg    <= 1'b0;
			tb_cnt_reg <= 8'h00;
			tb_reg     <= 1'b0;
			ctrl_reg   <= `DTDO_CTRL_RESET;
			ist_reg    <= 3'h0;
			imask_reg  <= 3'h0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'b00;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= 2'b00;
			awrdy_reg  <= 1'b0;
			ardy_reg   <= 1'b0;
		end else begin
			st_reg     <= st_next;
			code_reg   <= code_next;
			dv_reg     <= dv_next;
			det_d_reg  <= det_d_next;
			clr_d_reg  <= clr_d_next;
			oe_reg     <= oe_next;
			osc_reg    <= osc_next;
			irq_reg    <= irq_next;
			tb_cnt_reg <= tb_cnt_next;
			tb_reg     <= tb_next;
			ctrl_reg   <= ctrl_next;
			ist_reg    <= ist_next;
			imask_reg  <= imask_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
			awrdy_reg  <= awrdy_next;
			ardy_reg   <= ardy_next;
		end
	end

	// Ready straight from a flop, one cycle after the request stands
	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready  = awrdy_reg;
	assign s_axi_arready = ardy_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign code_out      = code_reg;
	assign code_oe       = {4{oe_reg}};
	assign digit_valid   = dv_reg;
	assign shared_timebase    = tb_reg;
	assign shared_timebase_oe = osc_reg;
	assign irq           = irq_reg;

	valid_after_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(dv_reg) |-> $stable(code_reg)) else $error("valid rose with changing code");
	pause_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_reg == dtdo_pkg::DTDO_ST_VALID && pause_s) |=> (!dv_reg && code_reg == 4'h0))
		else $error("pause did not clear outputs");
	inhibit_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
		(inhibit && pair_s.col == 2'd3 && st_reg == dtdo_pkg::DTDO_ST_IDLE)
		|=> st_reg == dtdo_pkg::DTDO_ST_IDLE) else $error("inhibited pair accepted");
	hex_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && fmt_hex && st_reg == dtdo_pkg::DTDO_ST_IDLE && pair_s == 4'hf)
		|=> code_reg == 4'h0) else $error("hex D code wrong");
	b28_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && !fmt_hex && st_reg == dtdo_pkg::DTDO_ST_IDLE && pair_s == 4'hd)
		|=> code_reg == 4'hd) else $error("two of eight zero code wrong");
	clear_drops_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_reg == dtdo_pkg::DTDO_ST_VALID && dv_reg && clr_rise && !pause_s) |=> !dv_reg)
		else $error("clear did not drop valid");
	oe_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		##1 code_oe == {4{$past(ctrl_reg[`DTDO_CTRL_OE_BIT])}})
		else $error("output enable mismatch");
	timebase_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		!osc_reg |=> !tb_reg) else $error("timebase runs while disabled");
endmodule : dtdo_decoder

// file: dv/dtdo_host_model.sv
`timescale 1ns/1ns
module dtdo_host_model (
	input  wire logic       clk,
	input  wire logic [3:0] code_out,
	input  wire logic [3:0] code_oe,
	input  wire logic       digit_valid,
	input  wire logic       ack_en,
	output logic [3:0]      bus,
	output logic            digit_valid_clear
);
	logic [3:0] last_reg;
	int         hold;
	initial begin
		last_reg = 4'h0;
		hold = 0;
		digit_valid_clear = 1'b0;
	end
	// Released bus shows inverse of last value, so stale data never passes
	assign bus = (&code_oe) ? code_out : ~last_reg;
	always @(posedge clk) begin
		if (&code_oe)
			last_reg <= code_out;
		// Pulse kept well above the minimum clear width
		if (hold > 0)
			hold <= hold - 1;
		else if (ack_en && digit_valid)
			hold <= 60;
		digit_valid_clear <= (hold > 0);
	end
endmodule : dtdo_host_model

// file: dv/dual_tone_digit_decoder_output_test.sv
`timescale 1ns/1ns
`include "dtdo_regs.svh"
module dual_tone_digit_decoder_output_test;
	logic        clk, rst_n, pair_detect, pause_detect, ack_en, clr;
	logic [1:0]  pair_row, pair_col, bresp, rresp, rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, dv, tb, tb_oe, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, code_out, code_oe, bus;
	int          bad_count, check_count, n;
	localparam logic [63:0] HEX = 64'h123d_456e_789f_bac0;

	dtdo_decoder uut (.clk(clk), .rst_n(rst_n), .pair_detect(pair_detect), .pair_row(pair_row),
		.pair_col(pair_col), .pause_detect(pause_detect), .digit_valid_clear(clr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.code_out(code_out), .code_oe(code_oe), .digit_valid(dv), .shared_timebase(tb),
		.shared_timebase_oe(tb_oe), .irq(irq));
	dtdo_host_model host (.clk(clk), .code_out(code_out), .code_oe(code_oe), .digit_valid(dv),
		.ack_en(ack_en), .bus(bus), .digit_valid_clear(clr));

	always #2 clk = ~clk;

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic hang();
		bad_count++;
		$display("ERROR %0t wait ran out", $time);
		stop_test();
	endtask : hang
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		for (int i = 0; i < 100 && !b; i++) begin
			@(negedge clk);
			aw = awready;
			w = wready;
			b = bvalid;
			rs = bresp;
			@(posedge clk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b)
			hang();
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		logic ar, r;
		r = 1'b0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (int i = 0; i < 100 && !r; i++) begin
			@(negedge clk);
			ar = arready;
			r = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge clk);
			if (ar)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!r)
			hang();
	endtask : rdr
	task automatic wait_dv(input logic lvl);
		int i;
		i = 0;
		while (dv !== lvl && i < 200) begin
			@(negedge clk);
			i++;
		end
		if (dv !== lvl)
			hang();
	endtask : wait_dv
	task automatic pair(input logic [3:0] k, input logic on, input logic pause);
		@(posedge clk);
		pair_row <= k[3:2];
		pair_col <= k[1:0];
		pair_detect <= on;
		pause_detect <= pause;
		@(negedge clk);
	endtask : pair
	task automatic tone(input logic [3:0] k, input logic [3:0] exp);
		pair(k, 1'b1, 1'b0);
		wait_dv(1'b1);
		chk(bus, exp);
		pair(k, 1'b0, 1'b1);
		wait_dv(1'b0);
		@(negedge clk);
		chk(code_out, 4'h0);
		pair(k, 1'b0, 1'b0);
	endtask : tone

	initial begin
		{clk, rst_n, pair_detect, pause_detect, ack_en, pair_row, pair_col} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{bad_count, check_count} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rdr(`DTDO_ADDR_CTRL);
		chk(rd, `DTDO_CTRL_RESET);
		rdr(8'h40);
		chk(rs, 2'b10);
		wr(8'h40, 32'h0);
		chk(rs, 2'b10);
		chk(tb_oe, 1'b0);
		$display("Test register map done");
		wr(`DTDO_ADDR_CTRL, 32'h05);
		for (int k = 0; k < 16; k++)
			tone(k[3:0], HEX[63 - 4 * k -: 4]);
		wr(`DTDO_ADDR_CTRL, 32'h04);
		for (int k = 0; k < 16; k++)
			tone(k[3:0], k[3:0]);
		$display("Test code formats done");
		wr(`DTDO_ADDR_CTRL, 32'h07);
		pair(4'h7, 1'b1, 1'b0);
		repeat (20) @(negedge clk);
		chk(dv, 1'b0);
		pair(4'h7, 1'b0, 1'b0);
		tone(4'h5, 4'h5);
		$display("Test inhibit done");
		wr(`DTDO_ADDR_CTRL, 32'h05);
		ack_en <= 1'b1;
		pair(4'h0, 1'b1, 1'b0);
		wait_dv(1'b1);
		wait_dv(1'b0);
		chk(code_out, 4'h1);
		ack_en <= 1'b0;
		pair(4'h0, 1'b0, 1'b1);
		repeat (10) @(negedge clk);
		pair(4'h0, 1'b0, 1'b0);
		$display("Test clear done");
		wr(`DTDO_ADDR_IRQ_STAT, 32'h07);
		wr(`DTDO_ADDR_IRQ_MASK, 32'h01);
		chk(irq, 1'b0);
		wr(`DTDO_ADDR_CTRL, 32'h01);
		pair(4'h1, 1'b1, 1'b0);
		wait_dv(1'b1);
		chk(code_oe, 4'h0);
		pair(4'h1, 1'b0, 1'b0);
		chk(irq, 1'b1);
		rdr(`DTDO_ADDR_IRQ_STAT);
		chk(rd[0], 1'b1);
		wr(`DTDO_ADDR_IRQ_MASK, 32'h00);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		wr(`DTDO_ADDR_IRQ_STAT, 32'h01);
		wr(`DTDO_ADDR_IRQ_MASK, 32'h01);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		$display("Test interrupt done");
		chk(dv, 1'b1);
		wr(`DTDO_ADDR_CTRL, 32'h11);
		repeat (2) @(negedge clk);
		chk(dv, 1'b0);
		rdr(`DTDO_ADDR_DIGIT);
		chk(rd, 32'h02);
		$display("Test software clear done");
		wr(`DTDO_ADDR_CTRL, 32'h0d);
		for (n = 0; n < 200 && tb === 1'b0; n++)
			@(negedge clk);
		for (n = 0; n < 200 && tb === 1'b1; n++)
			@(negedge clk);
		chk(n, `DTDO_REF_HALF_CYC);
		chk(tb_oe, 1'b1);
		rdr(`DTDO_ADDR_STATUS);
		chk(rd[3:2], 2'b11);
		$display("Test timebase done");
		stop_test();
	end
	initial begin
		#400000;
		hang();
	end
endmodule : dual_tone_digit_decoder_output_test
